// *** phy_coding_pkg.sv ***
// Shared types, constants and coding functions for the line coding path
package phy_coding_pkg;

  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_t;
  typedef enum logic [1:0] {MLT_ZERO, MLT_PLUS, MLT_MINUS} mlt3_t;
  typedef logic signed [2:0] pam_t;
  typedef pam_t [3:0] pam4_t;
  typedef logic signed [7:0] samp_t;
  typedef samp_t [3:0] samp4_t;
  typedef struct packed {
    logic [7:0] data;
    logic gig;
  } xfer_t;

  localparam int PAIRS = 4;
  // Fast-mode scrambler: x^11 + x^9 + 1, 2047-bit period
  localparam int SCR_TAP = 8;
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  // Gigabit scrambler: x^33 + x^13 + 1, advanced eight bits per symbol
  localparam int GSCR_TAP = 12;
  localparam logic [32:0] GSCR_SEED = 33'h1FFFFFFFF;
  localparam logic [4:0] CODE_IDLE = 5'h1F;
  localparam logic [4:0] CODE_J = 5'h18;
  localparam logic [2:0] BIT_LAST = 3'h4;
  localparam logic [5:0] LOCK_RUN = 6'h10;
  localparam logic [2:0] GIG_GRACE = 3'h6;
  localparam int SLICE_HI = 48;
  localparam int SLICE_LO = 16;
  localparam int SYM_LIMIT = 512;

  // Four data bits to a five-bit code group
  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    logic [4:0] t [16];
    t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
          5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    return t[nib];
  endfunction : enc4b5b

  // Code group back to {hit, data bits}; hit low for non-data codes
  function automatic logic [4:0] dec4b5b(input logic [4:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc4b5b(4'(i)) == code) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec4b5b

  // Advance the gigabit scrambler by one symbol
  function automatic logic [32:0] gstep(input logic [32:0] s);
    logic [32:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[31:0], r[32] ^ r[GSCR_TAP]};
    end
    return r;
  endfunction : gstep

  // Nine-bit symbol to four base-five digits, one five-level point per pair
  function automatic pam4_t pam_enc(input logic [8:0] sym);
    pam4_t r;
    int v;
    v = int'(sym);
    for (int p = 0; p < PAIRS; p++) begin
      r[p] = 3'(v % 5 - 2);
      v = v / 5;
    end
    return r;
  endfunction : pam_enc

endpackage : phy_coding_pkg

// *** phy_line_coding_path.sv ***
// Fast Ethernet and gigabit line coding datapath with MAC-side handshake
// Notes on behaviour
// - Fast transmit: serialize, 4B5B, scramble, NRZI, MLT3.
// - Serialize MAC nibbles to a 125 MHz stream.
// - Fast receive: MLT3, NRZI, NRZ, descramble, decode, deserialize.
// - Recovered symbol clock turns NRZI into NRZ.
// - Decoded bits become MAC words on receive.
// - Gigabit: octet scrambled to 9 bits, PAM5 mapped.
// - Resolve seed, skew, order, polarity from idle first.
// - Aligned PAM5 symbols become 9 bits, then octets.
// - Slave transmitter runs on the recovered clock.
// - Gigabit sends and receives on four pairs together.
// - Echo and three crosstalk cancelers per receive pair.
// - Correct pair swaps, polarity and pair skew.
// - 11-bit LFSR, 2047-bit sequence, same at receiver.
// - 11-bit scrambler used only at 100 Mbit/s.
`timescale 1ns/1ns
`default_nettype none
module phy_line_coding_path import phy_coding_pkg::*; #(
  parameter int SKEW_W = 2,
  parameter samp_t ECHO_W = 8'sh04,
  parameter samp_t NEXT_W = 8'sh02
) (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Line symbol clock, recovered from the receive data
  input wire logic i_lclk,
  // MAC side
  input wire speed_t i_speed,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_locked,
  // Line side
  output var mlt3_t o_tx_mlt3,
  output var pam4_t o_tx_pam,
  input wire mlt3_t i_rx_mlt3,
  input wire samp4_t i_rx_samp
);

  localparam int DEPTH = 2 ** SKEW_W;
  localparam int CFG_W = 2 + PAIRS + PAIRS * SKEW_W;

  logic [7:0] thold_q, thold_d;
  logic treq_q, treq_d, tack_s1_q, tack_s2_q, ready_d;
  logic rtog_s1_q, rtog_s2_q, rtog_s3_q, lk_s1_q, valid_d;
  logic [7:0] rdata_d;
  logic [1:0] lrst_q;
  logic lrst;
  speed_t spd_s1_q, spd_q;
  logic trq_s1_q, trq_s2_q, tack_q, tack_d, pending;
  logic [4:0] sh_q, sh_d;
  logic [2:0] bcnt_q, bcnt_d;
  logic infr_q, infr_d, txs, nrzi_q, nrzi_d, lastpos_q, lastpos_d;
  logic [10:0] scr_q, scr_d;
  mlt3_t mlt_d;
  logic [32:0] gscr_q, gscr_d;
  pam4_t pam_d;
  logic [8:0] tsym;
  logic tflag;
  xfer_t rhold_q, rhold_d;
  logic rtog_q, lock100_q, lock100_d, glock_q, glock_d;

  // System-domain transmit handshake: one word held until the link acknowledges
  always_comb begin
    thold_d = thold_q;
    treq_d = treq_q;
    ready_d = o_tx_ready;
    if (o_tx_ready && i_tx_valid) begin
      thold_d = i_tx_data;
      treq_d = ~treq_q;
      ready_d = 1'b0;
    end else if (!o_tx_ready && tack_s2_q == treq_q) begin
      ready_d = 1'b1;
    end
  end

  // System-domain receive: toggle edge marks a new word in the link hold register
  always_comb begin
    valid_d = rtog_s2_q ^ rtog_s3_q;
    rdata_d = valid_d ? rhold_q.data : o_rx_data;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      thold_q <= 8'h00;
      treq_q <= 1'b0;
      o_tx_ready <= 1'b1;
      {tack_s1_q, tack_s2_q} <= 2'b00;
      {rtog_s1_q, rtog_s2_q, rtog_s3_q} <= 3'b000;
      {lk_s1_q, o_rx_locked} <= 2'b00;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end else begin
      thold_q <= thold_d;
      treq_q <= treq_d;
      o_tx_ready <= ready_d;
      {tack_s1_q, tack_s2_q} <= {tack_q, tack_s1_q};
      {rtog_s1_q, rtog_s2_q, rtog_s3_q} <= {rtog_q, rtog_s1_q, rtog_s2_q};
      {lk_s1_q, o_rx_locked} <= {lock100_q | glock_q, lk_s1_q};
      o_rx_valid <= valid_d;
      o_rx_data <= rdata_d;
    end
  end

  // Link reset: asserted at once, released on the line clock
  always_ff @(posedge i_lclk or posedge i_rst) begin
    if (i_rst) begin
      lrst_q <= 2'b11;
    end else begin
      lrst_q <= {lrst_q[0], 1'b0};
    end
  end
  assign lrst = lrst_q[1];
  assign pending = trq_s2_q != tack_q;

  // Link transmit: serializer, 4B5B, scrambler, NRZI, MLT3 and gigabit PAM5
  always_comb begin
    sh_d = sh_q;
    bcnt_d = bcnt_q + 3'h1;
    infr_d = infr_q;
    tack_d = tack_q;
    mlt_d = o_tx_mlt3;
    lastpos_d = lastpos_q;
    txs = (spd_q == SPD_100) ? sh_q[4] ^ scr_q[10] : sh_q[4];
    scr_d = {scr_q[9:0], scr_q[10] ^ scr_q[SCR_TAP]};
    nrzi_d = nrzi_q ^ txs;
    if (txs) begin
      mlt_d = MLT_ZERO;
      lastpos_d = (o_tx_mlt3 == MLT_PLUS);
      if (o_tx_mlt3 == MLT_ZERO) begin
        mlt_d = lastpos_q ? MLT_MINUS : MLT_PLUS;
      end
    end
    if (bcnt_q == BIT_LAST) begin
      bcnt_d = 3'h0;
      if (pending && spd_q != SPD_1000) begin
        if (!infr_q) begin
          sh_d = CODE_J;
          infr_d = 1'b1;
        end else begin
          sh_d = enc4b5b(thold_q[3:0]);
          tack_d = ~tack_q;
        end
      end else begin
        sh_d = CODE_IDLE;
        infr_d = 1'b0;
      end
    end else begin
      sh_d = {sh_q[3:0], 1'b1};
    end
    gscr_d = gstep(gscr_q);
    tflag = (spd_q == SPD_1000) && pending;
    if (tflag) begin
      tack_d = ~tack_q;
    end
    tsym = {tflag ^ gscr_q[8], (tflag ? thold_q : 8'h00) ^ gscr_q[7:0]};
    pam_d = (spd_q == SPD_1000) ? pam_enc(tsym) : '0;
  end

  // Transmit state runs on the recovered line clock so a slave stays locked
  always_ff @(posedge i_lclk or posedge lrst) begin
    if (lrst) begin
      {spd_s1_q, spd_q} <= {SPD_10, SPD_10};
      {trq_s1_q, trq_s2_q} <= 2'b00;
      tack_q <= 1'b0;
      sh_q <= CODE_IDLE;
      bcnt_q <= 3'h0;
      infr_q <= 1'b0;
      scr_q <= SCR_SEED;
      nrzi_q <= 1'b0;
      o_tx_mlt3 <= MLT_ZERO;
      lastpos_q <= 1'b0;
      gscr_q <= GSCR_SEED;
      o_tx_pam <= '0;
    end else begin
      {spd_s1_q, spd_q} <= {i_speed, spd_s1_q};
      {trq_s1_q, trq_s2_q} <= {treq_q, trq_s1_q};
      tack_q <= tack_d;
      sh_q <= sh_d;
      bcnt_q <= bcnt_d;
      infr_q <= infr_d;
      scr_q <= scr_d;
      nrzi_q <= nrzi_d;
      o_tx_mlt3 <= mlt_d;
      lastpos_q <= lastpos_d;
      gscr_q <= gscr_d;
      o_tx_pam <= pam_d;
    end
  end

  mlt3_t mq_q, mprev_q;
  logic rnrzi_q, rnrzi_d, rnrz, rkey, rplain, rmatch, emit100;
  logic [10:0] rhist_q, rhist_d;
  logic [5:0] rrun_q, rrun_d;
  logic ralign_q, ralign_d;
  logic [4:0] rsh_q, rsh_d, rdec;
  logic [2:0] rcnt_q, rcnt_d;

  // Fast receive: MLT3 to NRZI to NRZ, idle-locked descrambler, code alignment
  always_comb begin
    rnrzi_d = rnrzi_q ^ (mq_q != mprev_q);
    rnrz = rnrzi_d ^ rnrzi_q;
    rkey = rhist_q[10] ^ rhist_q[SCR_TAP];
    rmatch = (~rnrz) == rkey;
    rhist_d = {rhist_q[9:0], lock100_q ? rkey : ~rnrz};
    rrun_d = rmatch ? rrun_q + 6'h01 : 6'h00;
    lock100_d = (spd_q == SPD_100) && (lock100_q || rrun_d == LOCK_RUN);
    rplain = (spd_q == SPD_100) ? rnrz ^ rkey : rnrz;
    rsh_d = {rsh_q[3:0], rplain};
    rcnt_d = rcnt_q + 3'h1;
    ralign_d = ralign_q;
    rdec = dec4b5b(rsh_d);
    emit100 = 1'b0;
    if (!ralign_q) begin
      ralign_d = (rsh_d == CODE_J) && (lock100_q || spd_q == SPD_10);
      rcnt_d = 3'h0;
    end else if (rcnt_q == BIT_LAST) begin
      rcnt_d = 3'h0;
      ralign_d = rsh_d != CODE_IDLE;
      emit100 = rdec[4];
    end
  end

  always_ff @(posedge i_lclk or posedge lrst) begin
    if (lrst) begin
      {mq_q, mprev_q} <= {MLT_ZERO, MLT_ZERO};
      rnrzi_q <= 1'b0;
      rhist_q <= SCR_SEED;
      rrun_q <= 6'h00;
      lock100_q <= 1'b0;
      rsh_q <= CODE_IDLE;
      rcnt_q <= 3'h0;
      ralign_q <= 1'b0;
    end else begin
      {mq_q, mprev_q} <= {i_rx_mlt3, mq_q};
      rnrzi_q <= rnrzi_d;
      rhist_q <= rhist_d;
      rrun_q <= lock100_q ? 6'h00 : rrun_d;
      lock100_q <= lock100_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      ralign_q <= ralign_d;
    end
  end

  samp4_t rx_q;
  logic [2:0] dl_q [PAIRS][DEPTH];
  logic [2:0] dl_d [PAIRS][DEPTH];
  logic [2:0] dg [PAIRS];
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [32:0] grx_q, grx_d, gpred;
  logic [5:0] grun_q, grun_d;
  logic [2:0] grace_q, grace_d;
  logic gemit, gmatch;
  logic [8:0] gsym;
  // Sample register carries the echo of the symbol sent one clock earlier
  pam4_t txd_q;

  // Gigabit receive: cancel, slice, fix polarity, skew and pair order, then decode
  always_comb begin
    int acc;
    int v;
    int sk;
    acc = 0;
    v = 0;
    sk = 0;
    for (int p = 0; p < PAIRS; p++) begin
      acc = int'(rx_q[p]) - int'(ECHO_W) * int'(txd_q[p]);
      for (int o = 0; o < PAIRS; o++) begin
        if (o != p) begin
          acc = acc - int'(NEXT_W) * int'(txd_q[o]);
        end
      end
      dl_d[p][0] = (acc >= SLICE_HI) ? 3'h4 : (acc >= SLICE_LO) ? 3'h3 :
                   (acc > -SLICE_LO) ? 3'h2 : (acc > -SLICE_HI) ? 3'h1 : 3'h0;
      if (cfg_q[2+p]) begin
        dl_d[p][0] = 3'h4 - dl_d[p][0];
      end
      for (int k = 1; k < DEPTH; k++) begin
        dl_d[p][k] = dl_q[p][k-1];
      end
      sk = int'(cfg_q[2+PAIRS+p*SKEW_W +: SKEW_W]);
      dg[p] = dl_d[p][sk];
    end
    v = cfg_q[0] ? int'(dg[1]) + 5 * int'(dg[0]) : int'(dg[0]) + 5 * int'(dg[1]);
    v = v + (cfg_q[1] ? 25 * int'(dg[3]) + 125 * int'(dg[2])
                      : 25 * int'(dg[2]) + 125 * int'(dg[3]));
    gsym = 9'(v);
    gpred = gstep(grx_q);
    gmatch = (v < SYM_LIMIT) && (gsym == gpred[8:0]);
    grx_d = glock_q ? gpred : {gpred[32:8], gsym[7:0]};
    grun_d = gmatch ? grun_q + 6'h01 : 6'h00;
    grace_d = (grace_q == 3'h0) ? 3'h0 : grace_q - 3'h1;
    cfg_d = cfg_q;
    if (!glock_q && !gmatch && grace_q == 3'h0) begin
      cfg_d = cfg_q + 1'b1;
      grace_d = GIG_GRACE;
    end
    glock_d = (spd_q == SPD_1000) && (glock_q ? v < SYM_LIMIT : grun_d == LOCK_RUN);
    gemit = glock_q && (gsym[8] ^ gpred[8]);
    rhold_d = rhold_q;
    if (gemit) begin
      rhold_d = '{data: gsym[7:0] ^ gpred[7:0], gig: 1'b1};
    end else if (emit100) begin
      rhold_d = '{data: {4'h0, rdec[3:0]}, gig: 1'b0};
    end
  end

  always_ff @(posedge i_lclk or posedge lrst) begin
    if (lrst) begin
      rx_q <= '0;
      txd_q <= '0;
      dl_q <= '{default: '{default: 3'h2}};
      cfg_q <= '0;
      grx_q <= GSCR_SEED;
      grun_q <= 6'h00;
      grace_q <= GIG_GRACE;
      glock_q <= 1'b0;
      rhold_q <= '0;
      rtog_q <= 1'b0;
    end else begin
      rx_q <= i_rx_samp;
      txd_q <= o_tx_pam;
      dl_q <= dl_d;
      cfg_q <= cfg_d;
      grx_q <= grx_d;
      grun_q <= glock_q ? 6'h00 : grun_d;
      grace_q <= grace_d;
      glock_q <= glock_d;
      rhold_q <= rhold_d;
      rtog_q <= rtog_q ^ (gemit | emit100);
    end
  end

  // Checks on the coding stages
  a_mlt3_hold: assert property (@(posedge i_lclk) disable iff (lrst)
    !txs |=> o_tx_mlt3 == $past(o_tx_mlt3)) else $error("MLT3 moved without a one");
  a_mlt3_cycle: assert property (@(posedge i_lclk) disable iff (lrst)
    txs && o_tx_mlt3 != MLT_ZERO |=> o_tx_mlt3 == MLT_ZERO) else $error("MLT3 skipped zero");
  a_nrzi_toggle: assert property (@(posedge i_lclk) disable iff (lrst)
    txs |=> nrzi_q != $past(nrzi_q)) else $error("NRZI did not toggle");
  a_scr_bypass: assert property (@(posedge i_lclk) disable iff (lrst)
    spd_q != SPD_100 |-> txs == sh_q[4]) else $error("Scrambler active off 100M");
  a_scr_alive: assert property (@(posedge i_lclk) disable iff (lrst)
    scr_q != 11'h000 && rhist_q != 11'h000 || !lock100_q) else $error("LFSR stuck");
  a_code_slot: assert property (@(posedge i_lclk) disable iff (lrst)
    bcnt_q == BIT_LAST |=> bcnt_q == 3'h0 ##4 bcnt_q == BIT_LAST) else $error("Slot length");
  a_gig_gate: assert property (@(posedge i_lclk) disable iff (lrst)
    gemit |-> glock_q && spd_q == SPD_1000) else $error("Gigabit data before lock");
  a_lock_run: assert property (@(posedge i_lclk) disable iff (lrst)
    $rose(glock_q) |-> $past(grun_q) == LOCK_RUN - 6'h01) else $error("Early lock");
  a_tx_pairs: assert property (@(posedge i_lclk) disable iff (lrst)
    tflag |=> o_tx_pam == pam_enc($past(tsym))) else $error("PAM map wrong");
  a_rx_nrz: assert property (@(posedge i_lclk) disable iff (lrst)
    mq_q != mprev_q |-> rnrz) else $error("Lost NRZ one");
  a_tx_ready_hs: assert property (@(posedge i_clk) disable iff (i_rst)
    o_tx_ready && i_tx_valid |=> !o_tx_ready ##1 !o_tx_ready) else $error("Ready early");
  a_rx_valid_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_valid |=> !o_rx_valid) else $error("Receive valid stuck");
  c_lock100: cover property (@(posedge i_lclk) disable iff (lrst) $rose(lock100_q));
  c_glock: cover property (@(posedge i_lclk) disable iff (lrst) $rose(glock_q));
  c_emit100: cover property (@(posedge i_lclk) disable iff (lrst) emit100);
  c_start: cover property (@(posedge i_lclk) disable iff (lrst) sh_q == CODE_J);

endmodule : phy_line_coding_path
`default_nettype wire

// *** phy_link_model.sv ***
// Loopback link partner adding local echo and crosstalk on each pair
`timescale 1ns/1ns
`default_nettype none
module phy_link_model import phy_coding_pkg::*; #(
  parameter samp_t ECHO_W = 8'sh04,
  parameter samp_t NEXT_W = 8'sh02
) (
  // Line symbol clock shared by both directions
  input wire logic i_lclk,
  // Line signals from the device
  input wire mlt3_t i_mlt3,
  input wire pam4_t i_pam,
  // Line signals to the device
  output var mlt3_t o_mlt3,
  output var samp4_t o_samp
);
  pam4_t far_q;

  // Far end repeats what it hears one symbol later, on the recovered clock
  always_ff @(posedge i_lclk) begin
    o_mlt3 <= i_mlt3;
    far_q <= i_pam;
  end

  // Each pair: far signal plus own echo plus crosstalk of the other three
  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      o_samp[p] = 8'(32 * int'(far_q[p]) + int'(ECHO_W) * int'(i_pam[p]));
      for (int q = 0; q < PAIRS; q++) begin
        if (q != p) begin
          o_samp[p] = o_samp[p] + 8'(int'(NEXT_W) * int'(i_pam[q]));
        end
      end
    end
  end
endmodule : phy_link_model
`default_nettype wire

// *** phy_line_coding_path_tb.sv ***
// Self-checking bench for the line coding path in loopback
`timescale 1ns/1ns
`default_nettype none
module phy_line_coding_path_tb import phy_coding_pkg::*; ();
  logic i_clk = 1'h0;
  logic i_lclk = 1'h0;
  logic i_rst = 1'h1;
  speed_t i_speed = SPD_100;
  logic i_tx_valid = 1'h0;
  logic [7:0] i_tx_data = 8'h00;
  logic o_tx_ready;
  logic o_rx_valid;
  logic [7:0] o_rx_data;
  logic o_rx_locked;
  mlt3_t o_tx_mlt3;
  mlt3_t i_rx_mlt3;
  pam4_t o_tx_pam;
  samp4_t i_rx_samp;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_chg = 0;
  logic [7:0] rxq [$];
  mlt3_t prev_q = MLT_ZERO;
  mlt3_t lastnz_q = MLT_MINUS;

  // System clock and an unrelated line clock
  always #5 i_clk = ~i_clk;
  initial begin
    #7;
    forever #24 i_lclk = ~i_lclk;
  end

  // One skew bit per pair keeps a full order, polarity and skew search within the lock wait
  phy_line_coding_path #(.SKEW_W(1)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_lclk(i_lclk),
    .i_speed(i_speed), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
    .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
    .o_rx_locked(o_rx_locked), .o_tx_mlt3(o_tx_mlt3), .o_tx_pam(o_tx_pam),
    .i_rx_mlt3(i_rx_mlt3), .i_rx_samp(i_rx_samp));
  phy_link_model i_link (.i_lclk(i_lclk), .i_mlt3(o_tx_mlt3), .i_pam(o_tx_pam),
    .o_mlt3(i_rx_mlt3), .o_samp(i_rx_samp));

  // Collect received words
  always @(posedge i_clk) begin
    if (o_rx_valid === 1'h1) begin
      rxq.push_back(o_rx_data);
    end
  end

  // Line monitor: each level change must follow the 0,+,0,- cycle
  always @(posedge i_lclk) begin
    if (i_rst) begin
      prev_q <= MLT_ZERO;
      lastnz_q <= MLT_MINUS;
    end else if (o_tx_mlt3 !== prev_q) begin
      n_chg <= n_chg + 1;
      prev_q <= o_tx_mlt3;
      if (o_tx_mlt3 !== MLT_ZERO) begin
        lastnz_q <= o_tx_mlt3;
      end
      chk(o_tx_mlt3, (prev_q != MLT_ZERO) ? MLT_ZERO :
          ((lastnz_q == MLT_PLUS) ? MLT_MINUS : MLT_PLUS));
    end
  end

  // Compare one value and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic results();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Reset both domains at a given speed and check idle outputs
  task automatic do_reset(input speed_t s);
    @(posedge i_clk);
    i_rst <= 1'h1;
    i_speed <= s;
    i_tx_valid <= 1'h0;
    repeat (3) @(posedge i_clk);
    repeat (2) @(posedge i_lclk);
    chk(o_tx_ready, 32'h1);
    chk(o_rx_valid, 32'h0);
    chk(o_rx_locked, 32'h0);
    chk(o_tx_mlt3, MLT_ZERO);
    chk(o_tx_pam, 32'h0);
    @(posedge i_clk);
    i_rst <= 1'h0;
    rxq.delete();
  endtask : do_reset

  // Bounded wait for receive lock
  task automatic wait_lock();
    int n;
    n = 0;
    while (o_rx_locked !== 1'h1) begin
      @(posedge i_clk);
      n++;
      if (n > 40000) begin
        chk(32'h0, 32'h1);
        results();
      end
    end
  endtask : wait_lock

  // Offer one word and hold it until accepted
  task automatic put(input logic [7:0] d);
    int n;
    n = 0;
    i_tx_valid <= 1'h1;
    i_tx_data <= d;
    do begin
      @(posedge i_clk);
      n++;
      if (n > 400) begin
        chk(32'h0, 32'h1);
        results();
      end
    end while (o_tx_ready !== 1'h1);
  endtask : put

  // Send a frame back to back and compare what loops back
  task automatic frame(input logic [7:0] w [$], input logic [7:0] mask);
    int n;
    foreach (w[i]) put(w[i]);
    i_tx_valid <= 1'h0;
    n = 0;
    while (rxq.size() < w.size()) begin
      @(posedge i_clk);
      n++;
      if (n > 3000) begin
        chk(rxq.size(), w.size());
        results();
      end
    end
    foreach (w[i]) chk(rxq[i], w[i] & mask);
  endtask : frame

  // Line changes over sixteen bit times
  task automatic count_chg(output int c);
    int c0;
    c0 = n_chg;
    repeat (16) @(posedge i_lclk);
    c = n_chg - c0;
  endtask : count_chg

  // Fast mode: scrambled idle, lock, all sixteen nibbles with junk high bits
  task automatic sc_fast();
    logic [7:0] w [$];
    int c;
    do_reset(SPD_100);
    wait_lock();
    count_chg(c);
    chk(32'(c < 16), 32'h1);
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) w.push_back(8'(i * 17));
    frame(w, 8'h0F);
  endtask : sc_fast

  // Slow mode: idle unscrambled, every bit toggles the line
  task automatic sc_ten();
    int c;
    do_reset(SPD_10);
    repeat (12) @(posedge i_lclk);
    count_chg(c);
    chk(c, 32'h10);
    @(posedge i_clk);
    frame('{8'h3C, 8'h05, 8'hFA}, 8'h0F);
  endtask : sc_ten

  // Gigabit: word sent before lock is dropped, then octets loop back
  task automatic sc_gig();
    do_reset(SPD_1000);
    put(8'h77);
    i_tx_valid <= 1'h0;
    wait_lock();
    repeat (100) @(posedge i_clk);
    chk(rxq.size(), 32'h0);
    frame('{8'h00, 8'h5A, 8'hA5, 8'hFF, 8'h01, 8'h80}, 8'hFF);
  endtask : sc_gig

  // Main sequence
  initial begin
    sc_fast();
    sc_ten();
    sc_gig();
    results();
  end
endmodule : phy_line_coding_path_tb
`default_nettype wire
